//--- srrf_pkg.sv
// Constants, types and shared helpers of the stacked rotating register file.
// Assumes a single core clock domain; no software-visible registers.
package srrf_pkg;

	// Register numbering.
	localparam logic [6:0] SRRF_STK_BASE = 7'h20;
	localparam logic [6:0] SRRF_MAX_FRAME = 7'h60;
	localparam logic [8:0] SRRF_POOL_SIZE = 9'h080;
	localparam logic [2:0] SRRF_ROT_GRAN_MASK = 3'h7;

	// Fixed rotating regions of the predicate and floating-point files.
	localparam logic [6:0] SRRF_PR_ROT_BASE = 7'h10;
	localparam logic [6:0] SRRF_PR_ROT_SIZE = 7'h30;
	localparam logic [6:0] SRRF_FR_ROT_BASE = 7'h20;
	localparam logic [6:0] SRRF_FR_ROT_SIZE = 7'h60;

	// Write-back access sizes.
	localparam logic [1:0] SRRF_SIZE_1 = 2'h0;
	localparam logic [1:0] SRRF_SIZE_2 = 2'h1;
	localparam logic [1:0] SRRF_SIZE_4 = 2'h2;
	localparam logic [1:0] SRRF_SIZE_8 = 2'h3;

	// Reset values.
	localparam logic [63:0] SRRF_DATA_RESET = 64'h0;
	localparam logic [6:0] SRRF_FIELD_RESET = 7'h00;
	localparam logic [8:0] SRRF_COUNT_RESET = 9'h000;

	typedef enum logic [1:0] {
		SRRF_ENG_IDLE,
		SRRF_ENG_SPILL,
		SRRF_ENG_FILL
	} srrf_eng_type;

	// Narrow loads fill the upper bits with zero before they are stored.
	function automatic logic [63:0] srrf_zext(input logic [63:0] data,
		input logic [1:0] size);
		logic [63:0] res;
		res = data;
		case (size)
			SRRF_SIZE_1: res = {56'h0, data[7:0]};
			SRRF_SIZE_2: res = {48'h0, data[15:0]};
			SRRF_SIZE_4: res = {32'h0, data[31:0]};
			default: res = data;
		endcase
		return res;
	endfunction : srrf_zext

	// One rotation step of a rename base: down by one, wrapping at size.
	function automatic logic [6:0] srrf_rot_step(input logic [6:0] rrb,
		input logic [6:0] size);
		logic [6:0] res;
		res = SRRF_FIELD_RESET;
		if (size != SRRF_FIELD_RESET) begin
			res = (rrb == SRRF_FIELD_RESET) ? size - 7'h01 : rrb - 7'h01;
		end
		return res;
	endfunction : srrf_rot_step

endpackage : srrf_pkg

//--- srrf_rot_map.sv
// Rotating-region index map: turns a logical register number into an
// offset from the region base, rotated by the current rename base.
// Assumes rrb is always below size; purely combinational.
`timescale 1ns/1ps
module srrf_rot_map
	import srrf_pkg::*;
(
	input wire logic [6:0] idx,
	input wire logic [6:0] base,
	input wire logic [6:0] size,
	input wire logic [6:0] rrb,
	output logic in_region,
	output logic [6:0] rel
);
	logic [6:0] off;
	logic [7:0] sum;

	// Indices outside the region keep their plain offset untouched.
	always_comb begin
		off = idx - base;
		sum = {1'b0, off} + {1'b0, rrb};
		in_region = (idx >= base) && (off < size);
		rel = off;
		if (in_region) begin
			rel = (sum >= {1'b0, size}) ? 7'(sum - {1'b0, size}) : sum[6:0];
		end
	end

endmodule : srrf_rot_map

//--- srrf_loop_ctl.sv
// Counted-loop branch resolution around the loop count register.
// Assumes the pipeline writes the count and issues the branch as pulses.
`timescale 1ns/1ps
module srrf_loop_ctl
	import srrf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lc_wr_en,
	input wire logic [63:0] lc_wr_data,
	input wire logic cloop,
	output logic taken,
	output logic [63:0] loop_count_register
);
	typedef struct packed {
		logic [63:0] lc;
		logic taken;
	} srrf_loop_type;

	srrf_loop_type r;
	srrf_loop_type next_r;

	// The exit depends only on the count, never on a predicate.
	always_comb begin
		next_r = r;
		next_r.taken = 1'b0;
		if (cloop) begin
			if (r.lc != SRRF_DATA_RESET) begin
				next_r.lc = r.lc - 64'h1;
				next_r.taken = 1'b1;
			end
		end else if (lc_wr_en) begin
			next_r.lc = lc_wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign taken = r.taken;
	assign loop_count_register = r.lc;

endmodule : srrf_loop_ctl

//--- srrf_top.sv
// Stacked rotating integer register file with frame renaming, a stack
// spill engine, rotation of the rotating regions and counted-loop control.
// Assumes the pipeline issues at most one frame operation per cycle and
// holds frame operations, rotations and write-backs while BUSY is high.
`timescale 1ns/1ps
module srrf_top
	import srrf_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic ALLOC,
	input wire logic [6:0] ALLOC_SOF,
	input wire logic [6:0] ALLOC_SOL,
	input wire logic [6:0] ALLOC_SOR,
	input wire logic [6:0] STK_LIMIT,
	output logic ALLOC_FAULT,
	input wire logic CALL,
	input wire logic RET,
	input wire logic [6:0] RET_SOF,
	input wire logic [6:0] RET_SOL,
	input wire logic [6:0] RET_SOR,
	input wire logic ROTATE,
	input wire logic [6:0] RD_ADDR_A,
	output logic [63:0] RD_DATA_A,
	input wire logic [6:0] RD_ADDR_B,
	output logic [63:0] RD_DATA_B,
	input wire logic WB_EN,
	input wire logic [6:0] WB_ADDR,
	input wire logic [1:0] WB_SIZE,
	input wire logic [63:0] WB_DATA,
	input wire logic [6:0] FR_LOG,
	output logic [6:0] FR_PHYS,
	input wire logic [5:0] PR_LOG,
	output logic [5:0] PR_PHYS,
	input wire logic LC_WR_EN,
	input wire logic [63:0] LC_WR_DATA,
	input wire logic CLOOP,
	output logic CLOOP_TAKEN,
	output logic [63:0] LC_VALUE,
	output logic [6:0] FRAME_SOF,
	output logic BUSY,
	output logic SPILL_VALID,
	input wire logic SPILL_READY,
	output logic [63:0] SPILL_DATA,
	output logic FILL_REQ,
	input wire logic FILL_VALID,
	input wire logic [63:0] FILL_DATA
);
	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [31:0][63:0] glob;
		logic [127:0][63:0] stk;
		logic [6:0] bof;
		logic [6:0] sof;
		logic [6:0] sol;
		logic [6:0] sor;
		logic [6:0] rrb_gr;
		logic [6:0] rrb_fr;
		logic [6:0] rrb_pr;
		logic [8:0] ndirty;
		logic [6:0] pend_sof;
		logic [6:0] pend_sol;
		logic [6:0] pend_sor;
		srrf_eng_type eng;
		logic alloc_fault;
		logic [63:0] rd_a;
		logic [63:0] rd_b;
	} srrf_state_type;

	srrf_state_type r;
	srrf_state_type next_r;

	logic a_rot;
	logic b_rot;
	logic w_rot;
	logic fr_rot;
	logic pr_rot;
	logic [6:0] a_rel;
	logic [6:0] b_rel;
	logic [6:0] w_rel;
	logic [6:0] fr_rel;
	logic [6:0] pr_rel;
	logic [6:0] oldest;
	logic alloc_ok;

	////////////////////////////////////////////////////////////////////////
	// Rename maps for the read ports, the write port and the fixed regions.

	srrf_rot_map u_map_a (
		.idx(RD_ADDR_A), .base(SRRF_STK_BASE), .size(r.sor),
		.rrb(r.rrb_gr), .in_region(a_rot), .rel(a_rel)
	);
	srrf_rot_map u_map_b (
		.idx(RD_ADDR_B), .base(SRRF_STK_BASE), .size(r.sor),
		.rrb(r.rrb_gr), .in_region(b_rot), .rel(b_rel)
	);
	srrf_rot_map u_map_w (
		.idx(WB_ADDR), .base(SRRF_STK_BASE), .size(r.sor),
		.rrb(r.rrb_gr), .in_region(w_rot), .rel(w_rel)
	);
	srrf_rot_map u_map_fr (
		.idx(FR_LOG), .base(SRRF_FR_ROT_BASE), .size(SRRF_FR_ROT_SIZE),
		.rrb(r.rrb_fr), .in_region(fr_rot), .rel(fr_rel)
	);
	srrf_rot_map u_map_pr (
		.idx({1'b0, PR_LOG}), .base(SRRF_PR_ROT_BASE),
		.size(SRRF_PR_ROT_SIZE), .rrb(r.rrb_pr), .in_region(pr_rot),
		.rel(pr_rel)
	);

	// Rotated floating-point and predicate numbers are handed to their files.
	always_comb begin
		FR_PHYS = fr_rot ? 7'(SRRF_FR_ROT_BASE + fr_rel) : FR_LOG;
		PR_PHYS = pr_rot ? 6'(SRRF_PR_ROT_BASE + pr_rel) : PR_LOG;
	end

	////////////////////////////////////////////////////////////////////////
	// Counted loop.

	srrf_loop_ctl u_loop (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.lc_wr_en(LC_WR_EN),
		.lc_wr_data(LC_WR_DATA),
		.cloop(CLOOP),
		.taken(CLOOP_TAKEN),
		.loop_count_register(LC_VALUE)
	);

	////////////////////////////////////////////////////////////////////////
	// Logical to physical lookup.

	// Stacked numbers beyond the current frame read as zero.
	function automatic logic [63:0] read_reg(input srrf_state_type s,
		input logic [6:0] idx, input logic [6:0] rel);
		logic [63:0] res;
		logic [6:0] off;
		res = SRRF_DATA_RESET;
		off = idx - SRRF_STK_BASE;
		if (idx < SRRF_STK_BASE) begin
			res = s.glob[idx[4:0]];
		end else if (off < s.sof) begin
			res = s.stk[s.bof + rel];
		end
		return res;
	endfunction : read_reg

	// Oldest resident caller register, first to go out to memory.
	assign oldest = r.bof - r.ndirty[6:0];

	// A frame must fit the size cap, the limit and the granule.
	assign alloc_ok = (ALLOC_SOF <= SRRF_MAX_FRAME) &&
		(ALLOC_SOL <= ALLOC_SOF) && (ALLOC_SOR <= ALLOC_SOF) &&
		((ALLOC_SOR[2:0] & SRRF_ROT_GRAN_MASK) == 3'h0) &&
		({1'b0, ALLOC_SOF} + 8'h1F <= {1'b0, STK_LIMIT});

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Frame operations are taken only while the engine is idle; a return
	// whose caller was partly spilled waits in FILL until it is resident.
	always_comb begin
		next_r = r;
		next_r.alloc_fault = 1'b0;
		next_r.rd_a = read_reg(r, RD_ADDR_A, a_rel);
		next_r.rd_b = read_reg(r, RD_ADDR_B, b_rel);
		if (WB_EN && r.eng != SRRF_ENG_FILL) begin
			if (WB_ADDR < SRRF_STK_BASE) begin
				next_r.glob[WB_ADDR[4:0]] = srrf_zext(WB_DATA, WB_SIZE);
			end else if (7'(WB_ADDR - SRRF_STK_BASE) < r.sof) begin
				next_r.stk[r.bof + w_rel] = srrf_zext(WB_DATA, WB_SIZE);
			end
		end
		case (r.eng)
			SRRF_ENG_IDLE: begin
				if (RET) begin
					if (r.ndirty >= {2'b0, RET_SOL}) begin
						next_r.bof = r.bof - RET_SOL;
						next_r.ndirty = r.ndirty - {2'b0, RET_SOL};
						next_r.sof = RET_SOF;
						next_r.sol = RET_SOL;
						next_r.sor = RET_SOR;
						next_r.rrb_gr = SRRF_FIELD_RESET;
						next_r.rrb_fr = SRRF_FIELD_RESET;
						next_r.rrb_pr = SRRF_FIELD_RESET;
					end else begin
						next_r.pend_sof = RET_SOF;
						next_r.pend_sol = RET_SOL;
						next_r.pend_sor = RET_SOR;
						next_r.eng = SRRF_ENG_FILL;
					end
				end else if (CALL) begin
					// Outputs stay in place and become the callee's base.
					next_r.bof = r.bof + r.sol;
					next_r.ndirty = r.ndirty + {2'b0, r.sol};
					next_r.sof = r.sof - r.sol;
					next_r.sol = SRRF_FIELD_RESET;
					next_r.sor = SRRF_FIELD_RESET;
					next_r.rrb_gr = SRRF_FIELD_RESET;
					next_r.rrb_fr = SRRF_FIELD_RESET;
					next_r.rrb_pr = SRRF_FIELD_RESET;
				end else if (ALLOC) begin
					if (alloc_ok) begin
						next_r.sof = ALLOC_SOF;
						next_r.sol = ALLOC_SOL;
						next_r.sor = ALLOC_SOR;
						next_r.rrb_gr = SRRF_FIELD_RESET;
					end else begin
						next_r.alloc_fault = 1'b1;
					end
				end else if (ROTATE) begin
					next_r.rrb_gr = srrf_rot_step(r.rrb_gr, r.sor);
					next_r.rrb_fr = srrf_rot_step(r.rrb_fr,
						SRRF_FR_ROT_SIZE);
					next_r.rrb_pr = srrf_rot_step(r.rrb_pr,
						SRRF_PR_ROT_SIZE);
				end
				// Spill as soon as the resident set outgrows the pool.
				if (next_r.eng == SRRF_ENG_IDLE &&
					next_r.ndirty + {2'b0, next_r.sof} > SRRF_POOL_SIZE) begin
					next_r.eng = SRRF_ENG_SPILL;
				end
			end
			SRRF_ENG_SPILL: begin
				if (SPILL_READY) begin
					next_r.ndirty = r.ndirty - 9'h001;
					if (next_r.ndirty + {2'b0, r.sof} <= SRRF_POOL_SIZE) begin
						next_r.eng = SRRF_ENG_IDLE;
					end
				end
			end
			SRRF_ENG_FILL: begin
				if (FILL_VALID) begin
					// Last spilled register returns first, below the oldest.
					next_r.stk[oldest - 7'h01] = FILL_DATA;
					next_r.ndirty = r.ndirty + 9'h001;
				end
				if (r.ndirty >= {2'b0, r.pend_sol}) begin
					next_r.bof = r.bof - r.pend_sol;
					next_r.ndirty = r.ndirty - {2'b0, r.pend_sol};
					next_r.sof = r.pend_sof;
					next_r.sol = r.pend_sol;
					next_r.sor = r.pend_sor;
					next_r.rrb_gr = SRRF_FIELD_RESET;
					next_r.rrb_fr = SRRF_FIELD_RESET;
					next_r.rrb_pr = SRRF_FIELD_RESET;
					next_r.eng = SRRF_ENG_IDLE;
				end
			end
			default: next_r.eng = SRRF_ENG_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Spill data is muxed straight from the pool flops at the oldest slot.
	assign SPILL_VALID = (r.eng == SRRF_ENG_SPILL);
	assign SPILL_DATA = SPILL_VALID ? r.stk[oldest] : SRRF_DATA_RESET;
	assign FILL_REQ = (r.eng == SRRF_ENG_FILL) &&
		(r.ndirty < {2'b0, r.pend_sol});
	assign BUSY = (r.eng != SRRF_ENG_IDLE);
	assign ALLOC_FAULT = r.alloc_fault;
	assign RD_DATA_A = r.rd_a;
	assign RD_DATA_B = r.rd_b;
	assign FRAME_SOF = r.sof;

endmodule : srrf_top

//--- srrf_top_assertions.sv
// Port-level checks of the stacked rotating register file.
// Assumes it is bound to srrf_top and sees only that module's ports.
`timescale 1ns/1ps
module srrf_top_assertions
	import srrf_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic ALLOC,
	input wire logic [6:0] ALLOC_SOF,
	input wire logic [6:0] ALLOC_SOL,
	input wire logic [6:0] ALLOC_SOR,
	input wire logic [6:0] STK_LIMIT,
	input wire logic ALLOC_FAULT,
	input wire logic CALL,
	input wire logic RET,
	input wire logic ROTATE,
	input wire logic [6:0] RD_ADDR_A,
	input wire logic [63:0] RD_DATA_A,
	input wire logic WB_EN,
	input wire logic [6:0] WB_ADDR,
	input wire logic [1:0] WB_SIZE,
	input wire logic [6:0] FR_LOG,
	input wire logic [6:0] FR_PHYS,
	input wire logic [5:0] PR_LOG,
	input wire logic [5:0] PR_PHYS,
	input wire logic CLOOP,
	input wire logic CLOOP_TAKEN,
	input wire logic [63:0] LC_VALUE,
	input wire logic [6:0] FRAME_SOF,
	input wire logic BUSY,
	input wire logic SPILL_VALID,
	input wire logic FILL_REQ
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic go_alloc;
	logic go_rot;
	logic bad;
	// An operation counts only when idle and not preempted by priority.
	assign go_alloc = ALLOC && !BUSY && !RET && !CALL;
	assign go_rot = ROTATE && !BUSY && !RET && !CALL && !ALLOC;
	assign bad = ALLOC_SOF > 7'h60 || ALLOC_SOL > ALLOC_SOF
		|| ALLOC_SOR > ALLOC_SOF || ALLOC_SOR[2:0] != 3'h0
		|| {1'b0, ALLOC_SOF} + 8'h1F > {1'b0, STK_LIMIT};
	////////////////////////////////////////////////////////////////////////
	a_alloc_size: assert property (go_alloc && !bad |=>
		FRAME_SOF == $past(ALLOC_SOF) && !ALLOC_FAULT)
		else $error("legal allocation not applied");
	a_alloc_refuse: assert property (go_alloc && bad |=>
		ALLOC_FAULT && $stable(FRAME_SOF))
		else $error("bad allocation not refused");
	a_pr_global: assert property (PR_LOG < 6'h10 |->
		PR_PHYS == PR_LOG) else $error("low predicate renamed");
	a_fr_global: assert property (FR_LOG < 7'h20 |->
		FR_PHYS == FR_LOG) else $error("low float register renamed");
	a_pr_step: assert property (go_rot && PR_LOG >= 6'h10
		&& PR_LOG < 6'h3F ##1 PR_LOG == $past(PR_LOG) + 6'h01
		|-> PR_PHYS == $past(PR_PHYS)) else $error("predicate step wrong");
	a_fr_wrap: assert property (go_rot && FR_LOG == 7'h7F
		##1 FR_LOG == 7'h20 |-> FR_PHYS == $past(FR_PHYS))
		else $error("float top did not wrap to base");
	a_cloop_dec: assert property (CLOOP && LC_VALUE != 64'h0 |=>
		CLOOP_TAKEN && LC_VALUE == $past(LC_VALUE) - 64'h1)
		else $error("counted loop did not count down");
	a_cloop_exit: assert property (CLOOP && LC_VALUE == 64'h0 |=>
		!CLOOP_TAKEN) else $error("counted loop taken at zero");
	a_engine_busy: assert property (SPILL_VALID || FILL_REQ |-> BUSY)
		else $error("engine active without busy");
	a_zext_narrow: assert property (WB_EN && !BUSY
		&& WB_ADDR < 7'h20 && WB_SIZE != SRRF_SIZE_8
		##1 RD_ADDR_A == $past(WB_ADDR) && !WB_EN
		|=> RD_DATA_A[63:32] == 32'h0) else $error("narrow load not zeroed");
endmodule : srrf_top_assertions

//--- srrf_mem_model.sv
// Memory side of the stack spill engine: a word stack, last in first out.
// Assumes one clock with the design; it answers every other cycle.
`timescale 1ns/1ps
module srrf_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spill_valid,
	output logic spill_ready,
	input wire logic [63:0] spill_data,
	input wire logic fill_req,
	output logic fill_valid,
	output logic [63:0] fill_data
);
	logic [63:0] stk [256];
	logic [7:0] sp;
	logic ph;
	logic give;
	// Offer a word only on alternate cycles, so the engine must wait.
	assign give = fill_req && ph && !fill_valid && sp != 8'h00;
	// Idle fill data toggles so a stale word is never mistaken for valid.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp <= 8'h00;
			ph <= 1'b0;
			spill_ready <= 1'b0;
			fill_valid <= 1'b0;
			fill_data <= 64'h0;
		end else begin
			ph <= ~ph;
			spill_ready <= ph;
			if (spill_valid && spill_ready) begin
				stk[sp] <= spill_data;
				sp <= sp + 8'h01;
			end
			if (fill_valid) begin
				sp <= sp - 8'h01;
			end
			fill_valid <= give;
			fill_data <= give ? stk[sp - 8'h01] : ~fill_data;
		end
	end
endmodule : srrf_mem_model

//--- srrf_top_tb.sv
// Self-checking bench of the stacked rotating register file.
// Assumes the package, design, checker and memory model compile first.
`timescale 1ns/1ps
module srrf_top_tb;
	import srrf_pkg::*;
	logic clk = 0, rst_n = 0, alloc = 0, call = 0, ret = 0, rotate = 0;
	logic we = 0, lwe = 0, cloop = 0, srdy, fv, flt, fault, taken, busy;
	logic sv, freq;
	logic [6:0] sof = 0, sol = 0, sor = 0, ra = 0, wa = 0, frl = 0;
	logic [6:0] frp, fsof;
	logic [6:0] lim = 7'h7F;
	logic [5:0] prl = 0, prp;
	logic [1:0] ws = 0;
	logic [63:0] wd = 0, lwd = 0, rda, rdb, sdat, fdat, lcv, got;
	logic [6:0] r_addr [4] = '{7'h01, 7'h02, 7'h03, 7'h1F};
	logic [1:0] r_size [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [63:0] r_exp [4] = '{64'hF0, 64'hDEF0, 64'h9ABCDEF0,
		64'h123456789ABCDEF0};
	logic [6:0] f_sof [3] = '{7'h10, 7'h61, 7'h10};
	logic [6:0] f_sol [3] = '{7'h08, 7'h08, 7'h14};
	logic [6:0] f_sor [3] = '{7'h04, 7'h00, 7'h00};
	int num_errors = 0, total_checks = 0, cycles = 0, i;
	srrf_top srrf_top_i (.CLK_SYS(clk), .RST_N(rst_n), .ALLOC(alloc),
		.ALLOC_SOF(sof), .ALLOC_SOL(sol), .ALLOC_SOR(sor),
		.STK_LIMIT(lim), .ALLOC_FAULT(fault), .CALL(call), .RET(ret),
		.RET_SOF(sof), .RET_SOL(sol), .RET_SOR(sor), .ROTATE(rotate),
		.RD_ADDR_A(ra), .RD_DATA_A(rda), .RD_ADDR_B(ra), .RD_DATA_B(rdb),
		.WB_EN(we), .WB_ADDR(wa), .WB_SIZE(ws), .WB_DATA(wd),
		.FR_LOG(frl), .FR_PHYS(frp), .PR_LOG(prl), .PR_PHYS(prp),
		.LC_WR_EN(lwe), .LC_WR_DATA(lwd), .CLOOP(cloop),
		.CLOOP_TAKEN(taken), .LC_VALUE(lcv), .FRAME_SOF(fsof),
		.BUSY(busy), .SPILL_VALID(sv), .SPILL_READY(srdy),
		.SPILL_DATA(sdat), .FILL_REQ(freq), .FILL_VALID(fv),
		.FILL_DATA(fdat));
	srrf_mem_model srrf_mem_model_i (.clk(clk), .rst_n(rst_n),
		.spill_valid(sv), .spill_ready(srdy), .spill_data(sdat),
		.fill_req(freq), .fill_valid(fv), .fill_data(fdat));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e,
		input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			num_errors++;
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	// Each bus task starts and ends on a rising edge.
	task automatic wb(input logic [6:0] a, input logic [1:0] s,
		input logic [63:0] d);
		we <= 1'b1;
		wa <= a;
		ws <= s;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
		ra <= a;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [6:0] a);
		while (busy !== 1'b0) @(posedge clk);
		ra <= a;
		@(posedge clk);
		#1 got = rda;
		@(posedge clk);
	endtask : rd
	// Frame operation held for one edge, then until BUSY reads low after an edge.
	task automatic fop(input int k, input logic [6:0] f, l, r);
		{alloc, call, ret, rotate} <= 4'h8 >> k;
		sof <= f;
		sol <= l;
		sor <= r;
		@(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		{alloc, call, ret, rotate} <= 4'h0;
		if (k == 3) begin
			prl <= 6'h15;
			frl <= 7'h20;
		end
		#1 flt = fault;
		@(posedge clk);
	endtask : fop
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2.5 clk = ~clk;
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		repeat (11) @(posedge clk);
		#1 chk("sof reset", 0, fsof);
		chk("lc reset", 0, lcv);
		@(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wb(r_addr[i], r_size[i], 64'h123456789ABCDEF0);
			rd(r_addr[i]);
			chk("row a", r_exp[i], got);
			chk("row b", r_exp[i], rdb);
		end
		$display("rows done");
		fop(0, 7'h10, 7'h08, 7'h08);
		chk("no fault", 0, flt);
		wb(7'h20, SRRF_SIZE_8, 64'h5A5A);
		wb(7'h28, SRRF_SIZE_8, 64'hC0DE);
		chk("frame", 16, fsof);
		fop(1, 7'h00, 7'h00, 7'h00);
		rd(7'h20);
		chk("callee input", 64'hC0DE, got);
		chk("callee sof", 8, fsof);
		fop(0, 7'h60, 7'h60, 7'h00);
		fop(1, 7'h00, 7'h00, 7'h00);
		fop(0, 7'h60, 7'h60, 7'h00);
		fop(2, 7'h60, 7'h60, 7'h00);
		fop(2, 7'h10, 7'h08, 7'h08);
		rd(7'h20);
		chk("filled", 64'h5A5A, got);
		$display("frames done");
		for (i = 0; i < 8; i++) begin
			wb(7'h20 + 7'(i), SRRF_SIZE_8, 64'hA0 + 64'(i));
		end
		prl <= 6'h14;
		frl <= 7'h7F;
		fop(3, 7'h10, 7'h08, 7'h08);
		rd(7'h20);
		chk("rot top", 64'hA7, got);
		rd(7'h21);
		chk("rot step", 64'hA0, got);
		rd(7'h1F);
		chk("global", r_exp[3], got);
		chk("pr rot", 6'h14, prp);
		chk("fr rot", 7'h7F, frp);
		$display("rotate done");
		for (i = 0; i < 3; i++) begin
			fop(0, f_sof[i], f_sol[i], f_sor[i]);
			chk("fault", 1, flt);
			chk("kept sof", 16, fsof);
		end
		// A lower stack limit refuses a frame that would run past it.
		lim <= 7'h3F;
		fop(0, 7'h28, 7'h08, 7'h08);
		chk("limit fault", 1, flt);
		fop(0, 7'h20, 7'h08, 7'h08);
		chk("limit edge", 0, flt);
		chk("limit sof", 32, fsof);
		lim <= 7'h7F;
		$display("faults done");
		lwe <= 1'b1;
		lwd <= 64'h2;
		@(posedge clk);
		lwe <= 1'b0;
		for (i = 0; i < 3; i++) begin
			cloop <= 1'b1;
			@(posedge clk);
			cloop <= 1'b0;
			#1 chk("taken", i < 2, taken);
			chk("count", (i < 2) ? 1 - i : 0, lcv);
			@(posedge clk);
		end
		$display("loop done");
		// A reset in mid-run must clear the frame, the count and the file.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("sof mid reset", 0, fsof);
		chk("lc mid reset", 0, lcv);
		@(posedge clk);
		rst_n <= 1'b1;
		rd(7'h1F);
		chk("reg mid reset", 0, got);
		$display("reset done");
		end_sim();
	end
endmodule : srrf_top_tb
bind srrf_top srrf_top_assertions srrf_top_assertions_i (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ALLOC(ALLOC),
	.ALLOC_SOF(ALLOC_SOF), .ALLOC_SOL(ALLOC_SOL), .ALLOC_SOR(ALLOC_SOR),
	.STK_LIMIT(STK_LIMIT), .ALLOC_FAULT(ALLOC_FAULT), .CALL(CALL),
	.RET(RET), .ROTATE(ROTATE), .RD_ADDR_A(RD_ADDR_A),
	.RD_DATA_A(RD_DATA_A), .WB_EN(WB_EN), .WB_ADDR(WB_ADDR),
	.WB_SIZE(WB_SIZE), .FR_LOG(FR_LOG), .FR_PHYS(FR_PHYS),
	.PR_LOG(PR_LOG), .PR_PHYS(PR_PHYS), .CLOOP(CLOOP),
	.CLOOP_TAKEN(CLOOP_TAKEN), .LC_VALUE(LC_VALUE),
	.FRAME_SOF(FRAME_SOF), .BUSY(BUSY), .SPILL_VALID(SPILL_VALID),
	.FILL_REQ(FILL_REQ));
